// >>> logic/tamu_params.svh
// offsets, field positions and reset values of the address-update block
`ifndef TAMU_PARAMS_SVH
`define TAMU_PARAMS_SVH
`define TAMU_OFF_MODE       4'h0
`define TAMU_OFF_SRC        4'h4
`define TAMU_OFF_DST        4'h8
`define TAMU_OFF_CTRL       4'hC
`define TAMU_SRC_HI_BIT     7
`define TAMU_SRC_LO_BIT     6
`define TAMU_DST_HI_BIT     5
`define TAMU_DST_LO_BIT     4
`define TAMU_KIND_HI_BIT    3
`define TAMU_KIND_LO_BIT    2
`define TAMU_SIDE_BIT       1
`define TAMU_SIZE_BIT       0
`define TAMU_CTRL_XFER_BIT  0
`define TAMU_MODE_RESET     8'h00
`define TAMU_PTR_RESET      32'h0000_0000
`define TAMU_RESP_OKAY      2'b00
`define TAMU_RESP_SLVERR    2'b10
`endif

// >>> logic/tamu_pkg.sv
// types shared by the address-update block
package tamu_pkg;
   typedef enum logic [1:0] {
      TAMU_UPD_FIXED  = 2'b00,
      TAMU_UPD_FIXED1 = 2'b01,
      TAMU_UPD_INC    = 2'b10,
      TAMU_UPD_DEC    = 2'b11
   } tamu_update_e;
   typedef enum logic [0:0] {
      TAMU_WR_IDLE = 1'b0,
      TAMU_WR_RESP = 1'b1
   } tamu_wr_state_e;
endpackage

// >>> logic/tamu_top.sv
// transfer address-update logic with its AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "tamu_params.svh"

// Functional notes
// - 8-bit mode reg: src 7:6, dest 5:4, kind 3:2, side 1, size 0.
// - upper source mode bit 0 leaves the source pointer unchanged.
// - source mode 10 adds 1 (byte) or 2 (word) to the source pointer.
// - source mode 11 subtracts 1 (size 0) or 2 (size 1) from source.
// - with the upper dest mode bit at 0 the dest pointer stays fixed.
// - dest mode 10 adds 1 (size 0) or 2 (size 1) to the dest pointer.
// - dest mode 11 subtracts 1 (byte) or 2 (word) from the dest pointer.
module tamu_top
   import tamu_pkg::*;
#(
   parameter int PTR_W = 32
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [3:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [3:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             xfer_done,
   output logic [PTR_W-1:0]      source_pointer,
   output logic [PTR_W-1:0]      dest_pointer,
   output logic [1:0]            xfer_kind,
   output logic                  xfer_side_select,
   output logic                  unit_size_select
);

   logic [7:0]       transfer_mode_a_reg;
   logic [7:0]       transfer_mode_a_next;
   logic [PTR_W-1:0] src_reg;
   logic [PTR_W-1:0] src_next;
   logic [PTR_W-1:0] dst_reg;
   logic [PTR_W-1:0] dst_next;
   logic             done_reg;
   logic             done_next;
   logic             xfer_ff1_reg;
   logic             xfer_ff2_reg;
   logic             xfer_prev_reg;
   tamu_wr_state_e   wr_state_reg;
   tamu_wr_state_e   wr_state_next;
   logic [3:0]       aw_addr_reg;
   logic [3:0]       aw_addr_next;
   logic             aw_have_reg;
   logic             aw_have_next;
   logic [31:0]      w_data_reg;
   logic [31:0]      w_data_next;
   logic [3:0]       w_strb_reg;
   logic [3:0]       w_strb_next;
   logic             w_have_reg;
   logic             w_have_next;
   logic [1:0]       bresp_reg;
   logic [1:0]       bresp_next;
   logic             rvalid_reg;
   logic             rvalid_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic [1:0]       rresp_reg;
   logic [1:0]       rresp_next;
   logic [PTR_W-1:0] step;
   logic             wr_fire;
   logic [31:0]      wr_merged;
   logic [31:0]      rd_word;
   tamu_update_e     src_mode;
   tamu_update_e     dst_mode;

   // transfer-complete strobe comes from the controller outside; synchronised
   // ff1 feeds only ff2; the edge detector reads ff2 and its delayed copy
   always_ff @(posedge clock) begin
      if (rst) begin
         xfer_ff1_reg  <= 1'b0;
         xfer_ff2_reg  <= 1'b0;
         xfer_prev_reg <= 1'b0;
      end else begin
         xfer_ff1_reg  <= xfer_done;
         xfer_ff2_reg  <= xfer_ff1_reg;
         xfer_prev_reg <= xfer_ff2_reg;
      end
   end

   assign src_mode = tamu_update_e'(transfer_mode_a_reg[
                     `TAMU_SRC_HI_BIT:`TAMU_SRC_LO_BIT]);
   assign dst_mode = tamu_update_e'(transfer_mode_a_reg[
                     `TAMU_DST_HI_BIT:`TAMU_DST_LO_BIT]);
   assign step     = transfer_mode_a_reg[`TAMU_SIZE_BIT]
                     ? PTR_W'(2) : PTR_W'(1);

   // a held address or data blocks its channel until the response is taken
   assign s_axi_awready = (wr_state_reg == TAMU_WR_IDLE) && !aw_have_reg;
   assign s_axi_wready  = (wr_state_reg == TAMU_WR_IDLE) && !w_have_reg;
   assign s_axi_bvalid  = (wr_state_reg == TAMU_WR_RESP);
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   assign source_pointer   = src_reg;
   assign dest_pointer     = dst_reg;
   assign xfer_kind        = transfer_mode_a_reg[
                             `TAMU_KIND_HI_BIT:`TAMU_KIND_LO_BIT];
   assign xfer_side_select = transfer_mode_a_reg[`TAMU_SIDE_BIT];
   assign unit_size_select = transfer_mode_a_reg[`TAMU_SIZE_BIT];

   assign wr_fire = (wr_state_reg == TAMU_WR_IDLE) &&
                    (aw_have_reg || s_axi_awvalid) &&
                    (w_have_reg || s_axi_wvalid);

   // write channel: address and data accepted in either order
   always_comb begin
      logic [3:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      a = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
      d = w_have_reg ? w_data_reg : s_axi_wdata;
      s = w_have_reg ? w_strb_reg : s_axi_wstrb;
      wr_state_next = wr_state_reg;
      aw_addr_next  = aw_addr_reg;
      aw_have_next  = aw_have_reg;
      w_data_next   = w_data_reg;
      w_strb_next   = w_strb_reg;
      w_have_next   = w_have_reg;
      bresp_next    = bresp_reg;
      wr_merged     = 32'h0000_0000;
      case (wr_state_reg)
         TAMU_WR_IDLE: begin
            if (wr_fire) begin
               aw_addr_next  = a;
               w_data_next   = d;
               w_strb_next   = s;
               aw_have_next  = 1'b0;
               w_have_next   = 1'b0;
               wr_state_next = TAMU_WR_RESP;
               bresp_next    = (a == `TAMU_OFF_MODE || a == `TAMU_OFF_SRC ||
                                a == `TAMU_OFF_DST || a == `TAMU_OFF_CTRL)
                               ? `TAMU_RESP_OKAY : `TAMU_RESP_SLVERR;
            end else begin
               if (s_axi_awvalid && !aw_have_reg) begin
                  aw_addr_next = s_axi_awaddr;
                  aw_have_next = 1'b1;
               end
               if (s_axi_wvalid && !w_have_reg) begin
                  w_data_next = s_axi_wdata;
                  w_strb_next = s_axi_wstrb;
                  w_have_next = 1'b1;
               end
            end
            for (int i = 0; i < 4; i++) begin
               wr_merged[i*8 +: 8] = s[i] ? d[i*8 +: 8] : 8'h00;
            end
         end
         TAMU_WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_next = TAMU_WR_IDLE;
            end
         end
         default: begin
            wr_state_next = TAMU_WR_IDLE;
         end
      endcase
   end

   // register and pointer state; a software write to a pointer wins
   // over a hardware step in the same cycle so a reload is never lost
   always_comb begin
      logic [3:0] a;
      logic [3:0] s;
      a = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
      s = w_have_reg ? w_strb_reg : s_axi_wstrb;
      transfer_mode_a_next = transfer_mode_a_reg;
      src_next  = src_reg;
      dst_next  = dst_reg;
      done_next = xfer_ff2_reg && !xfer_prev_reg;
      // one step per completed transfer, settings of that moment
      if (done_reg) begin
         case (src_mode)
            TAMU_UPD_INC: src_next = src_reg + step;
            TAMU_UPD_DEC: src_next = src_reg - step;
            default:      src_next = src_reg;
         endcase
         case (dst_mode)
            TAMU_UPD_INC: dst_next = dst_reg + step;
            TAMU_UPD_DEC: dst_next = dst_reg - step;
            default:      dst_next = dst_reg;
         endcase
      end
      if (wr_fire) begin
         if (a == `TAMU_OFF_MODE && s[0]) begin
            transfer_mode_a_next = wr_merged[7:0];
         end
         if (a == `TAMU_OFF_SRC) begin
            for (int i = 0; i < 4; i++) begin
               if (s[i] && i*8 < PTR_W) begin
                  src_next = (src_next & ~(PTR_W'(8'hFF) << (i*8)))
                           | (PTR_W'(wr_merged[i*8 +: 8]) << (i*8));
               end
            end
         end
         if (a == `TAMU_OFF_DST) begin
            for (int i = 0; i < 4; i++) begin
               if (s[i] && i*8 < PTR_W) begin
                  dst_next = (dst_next & ~(PTR_W'(8'hFF) << (i*8)))
                           | (PTR_W'(wr_merged[i*8 +: 8]) << (i*8));
               end
            end
         end
         // software may also step the pointers by hand; a manual step in
         // the cycle of a transfer edge merges with it into one step
         if (a == `TAMU_OFF_CTRL && s[0] &&
             wr_merged[`TAMU_CTRL_XFER_BIT]) begin
            done_next = 1'b1;
         end
      end
   end

   // read channel answers one cycle after the address is taken
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         `TAMU_OFF_MODE: rd_word = {24'h00_0000, transfer_mode_a_reg};
         `TAMU_OFF_SRC:  rd_word = 32'(src_reg);
         `TAMU_OFF_DST:  rd_word = 32'(dst_reg);
         default:        rd_word = 32'h0000_0000;
      endcase
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rvalid_reg) begin
         if (s_axi_rready) begin
            rvalid_next = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_word;
         rresp_next  = (s_axi_araddr == `TAMU_OFF_MODE ||
                        s_axi_araddr == `TAMU_OFF_SRC ||
                        s_axi_araddr == `TAMU_OFF_DST ||
                        s_axi_araddr == `TAMU_OFF_CTRL)
                       ? `TAMU_RESP_OKAY : `TAMU_RESP_SLVERR;
      end
   end

   // mode register reset value is undefined in the device; zero here
   always_ff @(posedge clock) begin
      if (rst) begin
         transfer_mode_a_reg <= `TAMU_MODE_RESET;
         src_reg       <= PTR_W'(`TAMU_PTR_RESET);
         dst_reg       <= PTR_W'(`TAMU_PTR_RESET);
         done_reg      <= 1'b0;
         wr_state_reg  <= TAMU_WR_IDLE;
         aw_addr_reg   <= 4'h0;
         aw_have_reg   <= 1'b0;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         w_have_reg    <= 1'b0;
         bresp_reg     <= `TAMU_RESP_OKAY;
         rvalid_reg    <= 1'b0;
         rdata_reg     <= 32'h0000_0000;
         rresp_reg     <= `TAMU_RESP_OKAY;
      end else begin
         transfer_mode_a_reg <= transfer_mode_a_next;
         src_reg       <= src_next;
         dst_reg       <= dst_next;
         done_reg      <= done_next;
         wr_state_reg  <= wr_state_next;
         aw_addr_reg   <= aw_addr_next;
         aw_have_reg   <= aw_have_next;
         w_data_reg    <= w_data_next;
         w_strb_reg    <= w_strb_next;
         w_have_reg    <= w_have_next;
         bresp_reg     <= bresp_next;
         rvalid_reg    <= rvalid_next;
         rdata_reg     <= rdata_next;
         rresp_reg     <= rresp_next;
      end
   end

endmodule

// >>> tb/tamu_sva.sv
// assertion checker for the address-update block
`timescale 1ns/1ps
module tamu_sva #(
   parameter int PTR_W = 32
) (
   input logic             clock,
   input logic             rst,
   input logic [3:0]       s_axi_awaddr,
   input logic             s_axi_awvalid,
   input logic             s_axi_awready,
   input logic [31:0]      s_axi_wdata,
   input logic [3:0]       s_axi_wstrb,
   input logic             s_axi_wvalid,
   input logic             s_axi_wready,
   input logic             xfer_done,
   input logic [PTR_W-1:0] source_pointer,
   input logic [PTR_W-1:0] dest_pointer,
   input logic [1:0]       xfer_kind,
   input logic             xfer_side_select,
   input logic             unit_size_select
);
   logic [7:0]       mode_reg;
   logic [7:0]       mode_next;
   logic             xd_reg;
   logic             trig;
   logic             wr;
   logic [PTR_W-1:0] stp;
   // shadow assumes address and data arrive together, as the bench sends
   always_comb begin
      wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
      trig = xfer_done & ~xd_reg;
      stp = mode_reg[0] ? PTR_W'(2) : PTR_W'(1);
      mode_next = mode_reg;
      if (wr && s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
         mode_next = s_axi_wdata[7:0];
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= 8'h00;
         xd_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         xd_reg <= xfer_done;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_fields;
      wr && s_axi_awaddr == 4'h0 && s_axi_wstrb[0] |=>
         {xfer_kind, xfer_side_select, unit_size_select} == mode_reg[3:0];
   endproperty
   property p_src_fix;
      trig && !mode_reg[7] |-> ##4 $stable(source_pointer);
   endproperty
   property p_src_inc;
      trig && mode_reg[7:6] == 2'b10 |->
         ##4 source_pointer == $past(source_pointer) + stp;
   endproperty
   property p_src_dec;
      trig && mode_reg[7:6] == 2'b11 |->
         ##4 source_pointer == $past(source_pointer) - stp;
   endproperty
   property p_dst_fix;
      trig && !mode_reg[5] |-> ##4 $stable(dest_pointer);
   endproperty
   property p_dst_inc;
      trig && mode_reg[5:4] == 2'b10 |->
         ##4 dest_pointer == $past(dest_pointer) + stp;
   endproperty
   property p_dst_dec;
      trig && mode_reg[5:4] == 2'b11 |->
         ##4 dest_pointer == $past(dest_pointer) - stp;
   endproperty
   property p_once;
      $changed(source_pointer) || $changed(dest_pointer) |-> $past(trig, 4)
         || $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
   endproperty
   a_fields: assert property (p_fields) else $error("mode fields");
   a_src_fix: assert property (p_src_fix) else $error("source moved");
   a_src_inc: assert property (p_src_inc) else $error("source inc");
   a_src_dec: assert property (p_src_dec) else $error("source dec");
   a_dst_fix: assert property (p_dst_fix) else $error("dest moved");
   a_dst_inc: assert property (p_dst_inc) else $error("dest inc");
   a_dst_dec: assert property (p_dst_dec) else $error("dest dec");
   a_once: assert property (p_once) else $error("stray step");
   c_src_dec: cover property (trig && mode_reg[7:6] == 2'b11);
   c_dst_word: cover property (trig && mode_reg[5:4] == 2'b10 && mode_reg[0]);
   c_ctrl: cover property (wr && s_axi_awaddr == 4'hC);
   c_lane: cover property (wr && s_axi_awaddr == 4'h4 && s_axi_wstrb != 4'hF);
endmodule
bind tamu_top tamu_sva #(.PTR_W(PTR_W)) u_sva (
   .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .xfer_done,
   .source_pointer, .dest_pointer, .xfer_kind, .xfer_side_select,
   .unit_size_select);

// >>> tb/tamu_tb_top.sv
// self-checking bench for the address-update block
`timescale 1ns/1ps
`include "tamu_params.svh"
module tamu_tb_top;
   logic        clock, rst, xfer_done, xfer_side_select, unit_size_select;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, source_pointer, dest_pointer;
   logic [1:0]  s_axi_bresp, s_axi_rresp, xfer_kind;
   int          err_count, n_tests;
   tamu_top #(.PTR_W(32)) DUT (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_done,
      .source_pointer, .dest_pointer, .xfer_kind, .xfer_side_select,
      .unit_size_select);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic test_done;
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic hang(input int k);
      if (k >= 50) begin
         err_count++;
         $display("MISMATCH %0t bus wait ran out", $time);
         test_done();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      hang(k);
      s_axi_bready <= 1'b0;
      cmp(32'(s_axi_bresp), 32'(er));
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      hang(k);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, ed);
      cmp(32'(s_axi_rresp), 32'(er));
      @(posedge clock);
   endtask
   // sync chain needs four edges; eight leaves margin
   task automatic pulse(input int hold);
      xfer_done <= 1'b1;
      repeat (hold) @(posedge clock);
      xfer_done <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] p,
                                       input logic [1:0] m, input logic sz);
      logic [31:0] st;
      st = sz ? 32'h2 : 32'h1;
      if (!m[1]) return p;
      return m[0] ? p - st : p + st;
   endfunction
   task automatic sc_reset;
      rd(`TAMU_OFF_MODE, 32'h0, `TAMU_RESP_OKAY);
      rd(`TAMU_OFF_DST, 32'h0, `TAMU_RESP_OKAY);
      rd(4'h2, 32'h0, `TAMU_RESP_SLVERR);
      wr(4'h2, 32'hFF, 4'hF, `TAMU_RESP_SLVERR);
      wr(`TAMU_OFF_MODE, 32'hFF, 4'hE, `TAMU_RESP_OKAY);
      rd(`TAMU_OFF_MODE, 32'h0, `TAMU_RESP_OKAY);
   endtask
   task automatic sc_modes;
      logic [7:0] m;
      for (int i = 0; i < 32; i++) begin
         m = {i[4:1], i[2:1], i[3], i[0]};
         wr(`TAMU_OFF_SRC, 32'h0, 4'hF, `TAMU_RESP_OKAY);
         wr(`TAMU_OFF_DST, 32'hFFFF_FFFF, 4'hF, `TAMU_RESP_OKAY);
         wr(`TAMU_OFF_MODE, {24'h0, m}, 4'hF, `TAMU_RESP_OKAY);
         rd(`TAMU_OFF_MODE, {24'h0, m}, `TAMU_RESP_OKAY);
         cmp({28'h0, xfer_kind, xfer_side_select, unit_size_select},
             {28'h0, m[3:0]});
         pulse(2);
         rd(`TAMU_OFF_SRC, nxt(32'h0, m[7:6], m[0]),
            `TAMU_RESP_OKAY);
         rd(`TAMU_OFF_DST, nxt(32'hFFFF_FFFF, m[5:4], m[0]),
            `TAMU_RESP_OKAY);
      end
   endtask
   task automatic sc_once;
      wr(`TAMU_OFF_SRC, 32'h0, 4'hF, `TAMU_RESP_OKAY);
      wr(`TAMU_OFF_DST, 32'h10, 4'hF, `TAMU_RESP_OKAY);
      wr(`TAMU_OFF_MODE, 32'hE1, 4'hF, `TAMU_RESP_OKAY);
      pulse(5);
      pulse(2);
      wr(`TAMU_OFF_CTRL, 32'h1, 4'hF, `TAMU_RESP_OKAY);
      repeat (4) @(posedge clock);
      rd(`TAMU_OFF_SRC, 32'hFFFF_FFFA, `TAMU_RESP_OKAY);
      rd(`TAMU_OFF_DST, 32'h16, `TAMU_RESP_OKAY);
   endtask
   // byte lanes of a pointer write, and control writes that must not step
   task automatic sc_lanes;
      wr(`TAMU_OFF_SRC, 32'h1234_5678, 4'hF, `TAMU_RESP_OKAY);
      wr(`TAMU_OFF_SRC, 32'hAABB_CCDD, 4'h6, `TAMU_RESP_OKAY);
      rd(`TAMU_OFF_SRC, 32'h12BB_CC78, `TAMU_RESP_OKAY);
      wr(`TAMU_OFF_CTRL, 32'h0, 4'hF, `TAMU_RESP_OKAY);
      wr(`TAMU_OFF_CTRL, 32'h1, 4'hE, `TAMU_RESP_OKAY);
      repeat (4) @(posedge clock);
      rd(`TAMU_OFF_SRC, 32'h12BB_CC78, `TAMU_RESP_OKAY);
      rd(`TAMU_OFF_CTRL, 32'h0, `TAMU_RESP_OKAY);
   endtask
   initial begin
      rst = 1'b1;
      xfer_done = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = 12'h000;
      s_axi_wdata = 32'h0;
      err_count = 0;
      n_tests = 0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      sc_reset();
      sc_modes();
      sc_once();
      sc_lanes();
      test_done();
   end
endmodule
